//--- hdl/uhbp_pkg.sv
// package: constants for the usb peripheral host bus port
package uhbp_pkg;
    localparam int UHBP_DATA_W = 16;
    localparam int UHBP_ADDR_W = 6;
    localparam int UHBP_SPLIT_W = 8;
    localparam int UHBP_NREG = 64;
    localparam logic [15:0] UHBP_REG_RESET = 16'h0000;
    // polarity bits: 0 = active low (reset default)
    localparam logic UHBP_POL_RESET = 1'b0;
    // strobe-to-pulse width of the frame pulse in cycles
    localparam int UHBP_SOF_PULSE_CYC = 4;
    localparam logic [2:0] UHBP_SOF_CNT_MAX = 3'h4;
endpackage

//--- hdl/uhbp_port.sv
// host bus port: cpu strobe bus, dma handshake, interrupt and frame pulse
// ===========================================================================
// Notes on behaviour
// [R1] only act while chip select low
// [R2] drive data while select and read low
// [R3] low byte written on low strobe rise
// [R4] high byte written on high strobe rise
// [R5] separate mode: six word address lines
// [R6] mode pin low separate, high multiplexed
// [R7] mode captured at reset release
// [R8] muxed lines carry address then data
// [R9] address six pin becomes latch enable
// [R10] master keeps strobes idle through reset
// [R11] two dma request outputs, one per port
// [R12] shared pin: ack one or split strobe
// [R13] write direction: end pin is input
// [R14] read direction: device drives end pin
// [R15] interrupt low when events pending
// [R16] frame pulse low on each start-of-frame
// [R17] reset idles outputs high, data floats
// [R18] dma pin polarity programmable, default low
// [R19] split data pins driven only when selected
// [R20] unused ack pin: enable bit cleared
// [R21] unused end pin: enable bit cleared
// [R22] sixteen bit registers, byte halves
// [R23] cycle steal toggles request, burst holds
// [R24] address latched on latch enable fall
// [R25] one update per write strobe rise
`timescale 1ns/1ps
`default_nettype none
module uhbp_port
    import uhbp_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic CS_N_I,
    input wire logic RD_N_I,
    input wire logic LOW_BYTE_WRITE_STROBE_N_I,
    input wire logic HIGH_BYTE_WRITE_STROBE_N_I,
    input wire logic BUS_MODE_SELECT_I,
    input wire logic [UHBP_ADDR_W-1:0] WORD_ADDRESS_I,
    input wire logic [UHBP_DATA_W-1:0] HOST_DATA_I,
    output logic [UHBP_DATA_W-1:0] HOST_DATA_O,
    output logic HOST_DATA_OE_O,
    // core side dma status and configuration
    input wire logic [1:0] DMA_READY_I,
    input wire logic [1:0] DMA_BURST_I,
    input wire logic [1:0] DMA_READ_DIR_I,
    input wire logic [1:0] ACK_PIN_ENABLE_I,
    input wire logic [1:0] END_PIN_ENABLE_I,
    input wire logic [1:0] LAST_DATA_I,
    input wire logic [1:0] DMA_POLARITY_I,
    input wire logic SPLIT_BUS_ENABLE_I,
    input wire logic [UHBP_SPLIT_W-1:0] SPLIT_READ_DATA_I,
    output logic [1:0] DMA_REQUEST_N_O,
    input wire logic DMA_ACK_CH0_I,
    input wire logic DMA_ACK_CH1_SPLIT_STROBE_I,
    input wire logic [1:0] TRANSFER_END_I,
    output logic [1:0] TRANSFER_END_O,
    output logic [1:0] TRANSFER_END_OE_O,
    output logic [1:0] DMA_ACK_O,
    output logic SPLIT_STROBE_O,
    output logic [1:0] TRANSFER_END_IN_O,
    input wire logic [UHBP_SPLIT_W-1:0] SPLIT_DATA_I,
    output logic [UHBP_SPLIT_W-1:0] SPLIT_DATA_O,
    output logic SPLIT_DATA_OE_O,
    input wire logic EVENT_PENDING_I,
    input wire logic SOF_DETECT_I,
    output logic INTERRUPT_N_O,
    output logic FRAME_PULSE_N_O,
    output logic MUX_MODE_O
);
    // =======================================================================
    // register storage and bus state
    logic [UHBP_DATA_W-1:0] regs [UHBP_NREG];
    logic muxed, rst_seen;
    logic wl_q, wh_q, ale_q;
    logic [UHBP_ADDR_W-1:0] addr_lat;
    logic [UHBP_ADDR_W-1:0] addr, next_addr_lat;
    logic next_muxed, next_rst_seen;
    logic wl_rise, wh_rise;
    logic ale;

    // in mux mode the address-six pin is the latch enable
    assign ale = muxed ? WORD_ADDRESS_I[UHBP_ADDR_W-1] : 1'b0; // [R9]
    // [R25] edge detect: a rise fires for exactly one cycle
    assign wl_rise = LOW_BYTE_WRITE_STROBE_N_I && !wl_q;
    assign wh_rise = HIGH_BYTE_WRITE_STROBE_N_I && !wh_q;
    // [R5] [R8] address from pins or from the latch
    assign addr = muxed ? addr_lat : WORD_ADDRESS_I;

    // mode capture and address latch
    always_comb begin
        next_rst_seen = 1'b1;
        next_muxed = muxed;
        if (!rst_seen) begin
            next_muxed = BUS_MODE_SELECT_I; // [R6] [R7]
        end
        next_addr_lat = addr_lat;
        if (muxed && ale_q && !ale) begin
            next_addr_lat = HOST_DATA_I[6:1]; // [R24] [R8]
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            rst_seen <= 1'b0;
            muxed <= 1'b0;
            addr_lat <= '0;
            wl_q <= 1'b1;
            wh_q <= 1'b1;
            ale_q <= 1'b0;
        end else begin
            rst_seen <= next_rst_seen;
            muxed <= next_muxed;
            addr_lat <= next_addr_lat;
            wl_q <= LOW_BYTE_WRITE_STROBE_N_I;
            wh_q <= HIGH_BYTE_WRITE_STROBE_N_I;
            ale_q <= ale;
        end
    end

    // =======================================================================
    // register writes, one per byte lane; only inside chip select
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            for (int i = 0; i < UHBP_NREG; i++) begin
                regs[i] <= UHBP_REG_RESET; // [R17]
            end
        end else if (!CS_N_I) begin // [R1]
            if (wl_rise) begin
                regs[addr][7:0] <= HOST_DATA_I[7:0]; // [R3] [R22]
            end
            if (wh_rise) begin
                regs[addr][15:8] <= HOST_DATA_I[15:8]; // [R4] [R22]
            end
        end
    end

    // =======================================================================
    // read drive; data floats outside select and read
    logic next_hoe;
    logic [UHBP_DATA_W-1:0] next_hdata;
    always_comb begin
        next_hoe = !CS_N_I && !RD_N_I; // [R2] [R1]
        next_hdata = next_hoe ? regs[addr] : '0;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            HOST_DATA_OE_O <= 1'b0;
            HOST_DATA_O <= '0;
        end else begin
            HOST_DATA_OE_O <= next_hoe;
            HOST_DATA_O <= next_hdata;
        end
    end

    // =======================================================================
    // dma handshake per channel
    logic [1:0] req_act, next_req_act;
    logic [1:0] ack_act;
    logic [1:0] next_req_n, next_end_o, next_end_oe, next_end_in;
    logic [1:0] next_ack;
    logic next_sstb;
    logic [1:0] ack_raw;
    // ch1 ack shares its pin with the split strobe
    assign ack_raw = {DMA_ACK_CH1_SPLIT_STROBE_I, DMA_ACK_CH0_I};

    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            // [R18] polarity bit 0 means pins are active low
            assign ack_act[c] = ACK_PIN_ENABLE_I[c] &&
                (ack_raw[c] == DMA_POLARITY_I[c]) &&
                !(c == 1 && SPLIT_BUS_ENABLE_I); // [R12] [R20]
            always_comb begin
                // [R23] steal drops after each ack, burst holds
                next_req_act[c] = DMA_READY_I[c] &&
                    !(ack_act[c] && !DMA_BURST_I[c] && req_act[c]);
                next_req_n[c] = next_req_act[c] ? DMA_POLARITY_I[c]
                    : !DMA_POLARITY_I[c]; // [R11] [R18]
                // [R14] [R21] drive end only when reading and enabled
                next_end_oe[c] = END_PIN_ENABLE_I[c] && DMA_READ_DIR_I[c];
                next_end_o[c] = (LAST_DATA_I[c] && next_end_oe[c]) ?
                    DMA_POLARITY_I[c] : !DMA_POLARITY_I[c];
                // [R13] write direction: sample end as an input
                next_end_in[c] = END_PIN_ENABLE_I[c] &&
                    !DMA_READ_DIR_I[c] &&
                    (TRANSFER_END_I[c] == DMA_POLARITY_I[c]);
                next_ack[c] = ack_act[c];
            end
        end
    endgenerate

    always_comb begin
        // [R12] strobe role only when split bus chosen
        next_sstb = SPLIT_BUS_ENABLE_I && !DMA_ACK_CH1_SPLIT_STROBE_I;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            req_act <= 2'b00;
            DMA_REQUEST_N_O <= 2'b11; // [R17]
            TRANSFER_END_O <= 2'b11;
            TRANSFER_END_OE_O <= 2'b00;
            TRANSFER_END_IN_O <= 2'b00;
            DMA_ACK_O <= 2'b00;
            SPLIT_STROBE_O <= 1'b0;
        end else begin
            req_act <= next_req_act;
            DMA_REQUEST_N_O <= next_req_n;
            TRANSFER_END_O <= next_end_o;
            TRANSFER_END_OE_O <= next_end_oe;
            TRANSFER_END_IN_O <= next_end_in;
            DMA_ACK_O <= next_ack;
            SPLIT_STROBE_O <= next_sstb;
        end
    end

    // =======================================================================
    // split data bus, driven only in split mode on a read transfer
    logic next_soe;
    always_comb begin
        next_soe = SPLIT_BUS_ENABLE_I && DMA_READ_DIR_I[0]; // [R19]
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            SPLIT_DATA_OE_O <= 1'b0;
            SPLIT_DATA_O <= '0;
        end else begin
            SPLIT_DATA_OE_O <= next_soe;
            SPLIT_DATA_O <= next_soe ? SPLIT_READ_DATA_I : '0;
        end
    end

    // =======================================================================
    // interrupt and frame pulse; a fixed width keeps a short pulse visible
    logic [2:0] sof_cnt, next_sof_cnt;
    always_comb begin
        next_sof_cnt = sof_cnt;
        if (SOF_DETECT_I) begin
            next_sof_cnt = UHBP_SOF_CNT_MAX; // [R16]
        end else if (sof_cnt != 3'h0) begin
            next_sof_cnt = sof_cnt - 3'h1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            sof_cnt <= 3'h0;
            INTERRUPT_N_O <= 1'b1; // [R17]
            FRAME_PULSE_N_O <= 1'b1;
            MUX_MODE_O <= 1'b0;
        end else begin
            sof_cnt <= next_sof_cnt;
            INTERRUPT_N_O <= !EVENT_PENDING_I; // [R15]
            FRAME_PULSE_N_O <= (next_sof_cnt == 3'h0); // [R16]
            MUX_MODE_O <= next_muxed;
        end
    end

    // =======================================================================
    // checks
    AST_RD_DRIVE: assert property ( // [R2]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (!CS_N_I && !RD_N_I) |=> HOST_DATA_OE_O)
        else $error("data not driven on read");
    AST_RD_FLOAT: assert property ( // [R1]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        CS_N_I |=> !HOST_DATA_OE_O)
        else $error("data driven without select");
    AST_MODE_HOLD: assert property ( // [R7]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        rst_seen |=> $stable(muxed))
        else $error("bus mode changed after reset");
    AST_INT: assert property ( // [R15]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        EVENT_PENDING_I |=> !INTERRUPT_N_O)
        else $error("interrupt not asserted");
    AST_SOF: assert property ( // [R16]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        SOF_DETECT_I |=> !FRAME_PULSE_N_O [*4])
        else $error("frame pulse too short");
    AST_END_OE: assert property ( // [R14]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        !END_PIN_ENABLE_I[0] |=> !TRANSFER_END_OE_O[0])
        else $error("end pin driven while disabled");
    AST_END_IN: assert property ( // [R13]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        DMA_READ_DIR_I[0] |=> !TRANSFER_END_IN_O[0])
        else $error("end input taken while reading");
    AST_SPLIT: assert property ( // [R19]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        !SPLIT_BUS_ENABLE_I |=> !SPLIT_DATA_OE_O)
        else $error("split data driven while unused");
    AST_ACK_SPLIT: assert property ( // [R12]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        SPLIT_BUS_ENABLE_I |=> !DMA_ACK_O[1])
        else $error("channel one ack taken in split mode");
    AST_REQ_IDLE: assert property ( // [R11]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (!DMA_READY_I[0] && !DMA_POLARITY_I[0]) |=> DMA_REQUEST_N_O[0])
        else $error("request asserted without ready");
    AST_WR_LOW: assert property ( // [R3]
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (!CS_N_I && wl_rise && !wh_rise) |=>
        regs[$past(addr)][7:0] == $past(HOST_DATA_I[7:0]))
        else $error("low byte not stored");
endmodule
`default_nettype wire

//--- tb/uhbp_dma_model.sv
// partner model: external dma controller answering the request pins
`timescale 1ns/1ps
`default_nettype none
module uhbp_dma_model (
    input wire logic clk_i,
    input wire logic [1:0] req_n_i,
    input wire logic [1:0] pol_i,
    input wire logic slow_i,
    output logic [1:0] ack_o
);
    logic [1:0] skip = 2'h0;
    // one ack cycle per seen request, at the programmed level; slow mode
    // answers only every other cycle so the device sees late handshakes
    always @(posedge clk_i) begin
        for (int c = 0; c < 2; c++) begin
            skip[c] <= ~skip[c];
            if (req_n_i[c] == pol_i[c] && ack_o[c] != pol_i[c]
                && !(slow_i && skip[c]))
                ack_o[c] <= pol_i[c];
            else
                ack_o[c] <= ~pol_i[c];
        end
    end
endmodule
`default_nettype wire

//--- tb/uhbp_port_tb.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module uhbp_port_tb;
    import uhbp_pkg::*;
    // ==================================================================
    // signals, idle values at time zero
    logic CORE_CLK_I = 0, RESETN_I = 0, CS_N_I = 1, RD_N_I = 1;
    logic LOW_BYTE_WRITE_STROBE_N_I = 1, HIGH_BYTE_WRITE_STROBE_N_I = 1;
    logic BUS_MODE_SELECT_I = 0, SPLIT_BUS_ENABLE_I = 0, EVENT_PENDING_I = 0;
    logic SOF_DETECT_I = 0, slow = 0, strobe_n = 1;
    logic [UHBP_ADDR_W-1:0] WORD_ADDRESS_I = 6'h00;
    logic [UHBP_DATA_W-1:0] HOST_DATA_I = 16'h0000, HOST_DATA_O;
    logic [1:0] DMA_READY_I = 0, DMA_BURST_I = 0, DMA_READ_DIR_I = 0;
    logic [1:0] LAST_DATA_I = 0, DMA_POLARITY_I = 0, TRANSFER_END_I = 3;
    logic [1:0] ACK_PIN_ENABLE_I = 3, END_PIN_ENABLE_I = 3;
    logic [1:0] DMA_REQUEST_N_O, TRANSFER_END_O, TRANSFER_END_OE_O, DMA_ACK_O;
    logic [1:0] TRANSFER_END_IN_O, ack;
    logic [UHBP_SPLIT_W-1:0] SPLIT_READ_DATA_I = 0, SPLIT_DATA_I = 8'h3c;
    logic [UHBP_SPLIT_W-1:0] SPLIT_DATA_O;
    logic HOST_DATA_OE_O, DMA_ACK_CH0_I, SPLIT_STROBE_O, SPLIT_DATA_OE_O;
    logic DMA_ACK_CH1_SPLIT_STROBE_I, INTERRUPT_N_O, FRAME_PULSE_N_O;
    logic MUX_MODE_O;
    int error_cnt = 0, checked = 0, n, m = 0;
    // shared pin: split strobe once split mode is on, else channel one ack
    assign DMA_ACK_CH0_I = ack[0];
    assign DMA_ACK_CH1_SPLIT_STROBE_I = SPLIT_BUS_ENABLE_I ? strobe_n : ack[1];
    uhbp_port i_uhbp_port (
        .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .CS_N_I(CS_N_I),
        .RD_N_I(RD_N_I),
        .LOW_BYTE_WRITE_STROBE_N_I(LOW_BYTE_WRITE_STROBE_N_I),
        .HIGH_BYTE_WRITE_STROBE_N_I(HIGH_BYTE_WRITE_STROBE_N_I),
        .BUS_MODE_SELECT_I(BUS_MODE_SELECT_I),
        .WORD_ADDRESS_I(WORD_ADDRESS_I), .HOST_DATA_I(HOST_DATA_I),
        .HOST_DATA_O(HOST_DATA_O), .HOST_DATA_OE_O(HOST_DATA_OE_O),
        .DMA_READY_I(DMA_READY_I), .DMA_BURST_I(DMA_BURST_I),
        .DMA_READ_DIR_I(DMA_READ_DIR_I), .ACK_PIN_ENABLE_I(ACK_PIN_ENABLE_I),
        .END_PIN_ENABLE_I(END_PIN_ENABLE_I), .LAST_DATA_I(LAST_DATA_I),
        .DMA_POLARITY_I(DMA_POLARITY_I),
        .SPLIT_BUS_ENABLE_I(SPLIT_BUS_ENABLE_I),
        .SPLIT_READ_DATA_I(SPLIT_READ_DATA_I),
        .DMA_REQUEST_N_O(DMA_REQUEST_N_O), .DMA_ACK_CH0_I(DMA_ACK_CH0_I),
        .DMA_ACK_CH1_SPLIT_STROBE_I(DMA_ACK_CH1_SPLIT_STROBE_I),
        .TRANSFER_END_I(TRANSFER_END_I), .TRANSFER_END_O(TRANSFER_END_O),
        .TRANSFER_END_OE_O(TRANSFER_END_OE_O), .DMA_ACK_O(DMA_ACK_O),
        .SPLIT_STROBE_O(SPLIT_STROBE_O),
        .TRANSFER_END_IN_O(TRANSFER_END_IN_O),
        .SPLIT_DATA_I(SPLIT_DATA_I), .SPLIT_DATA_O(SPLIT_DATA_O),
        .SPLIT_DATA_OE_O(SPLIT_DATA_OE_O), .EVENT_PENDING_I(EVENT_PENDING_I),
        .SOF_DETECT_I(SOF_DETECT_I), .INTERRUPT_N_O(INTERRUPT_N_O),
        .FRAME_PULSE_N_O(FRAME_PULSE_N_O), .MUX_MODE_O(MUX_MODE_O));
    uhbp_dma_model i_uhbp_dma_model (.clk_i(CORE_CLK_I),
        .req_n_i(DMA_REQUEST_N_O), .pol_i(DMA_POLARITY_I), .slow_i(slow),
        .ack_o(ack));
    initial begin
        forever #5 CORE_CLK_I = ~CORE_CLK_I;
    end
    // ==================================================================
    // tasks
    task automatic chk(input string what, input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge CORE_CLK_I);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // select stays high through reset so no stray write lands
    task automatic do_reset(input logic mode);
        RESETN_I = 0;
        CS_N_I = 1;
        BUS_MODE_SELECT_I = mode;
        cyc(5);
        chk("rst req", 16'(DMA_REQUEST_N_O), 16'h3);
        chk("rst oe", 16'({HOST_DATA_OE_O, SPLIT_DATA_OE_O}), 16'h0);
        RESETN_I = 1;
        cyc(2);
    endtask
    // mux mode: address rides data lines 6:1 while latch enable is high
    task automatic adr(input logic [5:0] a);
        if (MUX_MODE_O === 1'b1) begin
            WORD_ADDRESS_I = 6'h20;
            HOST_DATA_I = {9'h000, a, 1'b0};
            cyc(2);
            WORD_ADDRESS_I = 6'h00;
            cyc(1);  // address held one edge past the latch enable fall
            HOST_DATA_I = 16'ha5a5;
        end else
            WORD_ADDRESS_I = a;
        cyc(1);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d,
                      input logic [1:0] ln);
        adr(a);
        CS_N_I = 0;
        HOST_DATA_I = d;
        LOW_BYTE_WRITE_STROBE_N_I = ~ln[0];
        HIGH_BYTE_WRITE_STROBE_N_I = ~ln[1];
        cyc(2);
        LOW_BYTE_WRITE_STROBE_N_I = 1;
        HIGH_BYTE_WRITE_STROBE_N_I = 1;
        cyc(1);
        HOST_DATA_I = ~d;
        cyc(2);
        CS_N_I = 1;
        cyc(1);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        adr(a);
        CS_N_I = 0;
        RD_N_I = 0;
        cyc(3);
        chk("read oe", 16'(HOST_DATA_OE_O), 16'h1);
        chk("read data", HOST_DATA_O, exp);
        RD_N_I = 1;
        CS_N_I = 1;
        cyc(2);
        chk("released oe", 16'(HOST_DATA_OE_O), 16'h0);
    endtask
    // ==================================================================
    // hang guard
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
    // ==================================================================
    // main sequence
    initial begin
        do_reset(1'b0);
        chk("idle int", 16'(INTERRUPT_N_O), 16'h1);
        chk("idle sof", 16'(FRAME_PULSE_N_O), 16'h1);
        chk("sep mode", 16'(MUX_MODE_O), 16'h0);
        wr(6'h05, 16'h1234, 2'b11);
        rd(6'h05, 16'h1234);
        wr(6'h05, 16'habcd, 2'b01);
        rd(6'h05, 16'h12cd);
        wr(6'h05, 16'h5678, 2'b10);
        wr(6'h3f, 16'hbeef, 2'b11);
        rd(6'h3f, 16'hbeef);
        // strobes and read with select high: nothing shown or stored
        LOW_BYTE_WRITE_STROBE_N_I = 0;
        HIGH_BYTE_WRITE_STROBE_N_I = 0;
        RD_N_I = 0;
        cyc(2);
        chk("unselected oe", 16'(HOST_DATA_OE_O), 16'h0);
        LOW_BYTE_WRITE_STROBE_N_I = 1;
        HIGH_BYTE_WRITE_STROBE_N_I = 1;
        RD_N_I = 1;
        cyc(2);
        rd(6'h05, 16'h56cd);
        EVENT_PENDING_I = 1;
        cyc(3);
        chk("int on", 16'(INTERRUPT_N_O), 16'h0);
        EVENT_PENDING_I = 0;
        cyc(3);
        chk("int off", 16'(INTERRUPT_N_O), 16'h1);
        SOF_DETECT_I = 1;
        cyc(1);
        SOF_DETECT_I = 0;
        // the pulse starts on the edge that sees the detect, count it too
        n = int'(FRAME_PULSE_N_O === 1'b0);
        repeat (12) begin
            cyc(1);
            n += int'(FRAME_PULSE_N_O === 1'b0);
        end
        chk("sof width", 16'(n), 16'(UHBP_SOF_PULSE_CYC));
        // burst holds the request while the partner acks every other cycle
        DMA_BURST_I = 2'b11;
        DMA_READY_I = 2'b01;
        cyc(2);
        n = 0;
        repeat (20) begin
            cyc(1);
            n += int'(DMA_REQUEST_N_O !== 2'b10);
            m += int'(DMA_ACK_O[0] === 1'b1);
        end
        chk("burst hold", 16'(n), 16'h0);
        // partner acks every other cycle, so half the samples show it
        chk("burst ack", 16'(m), 16'd10);
        DMA_BURST_I = 2'b00;
        slow = 1;
        n = 0;
        repeat (20) begin
            cyc(1);
            n += int'(DMA_REQUEST_N_O[0] === 1'b1);
        end
        chk("steal drop", 16'(n > 0), 16'h1);
        DMA_BURST_I = 2'b11;
        DMA_POLARITY_I = 2'b11;
        DMA_READY_I = 2'b10;
        cyc(3);
        chk("pol high", 16'(DMA_REQUEST_N_O), 16'h2);
        DMA_POLARITY_I = 2'b00;
        DMA_READ_DIR_I = 2'b01;
        LAST_DATA_I = 2'b01;
        DMA_READY_I = 2'b01;
        TRANSFER_END_I = 2'b01;
        cyc(4);
        chk("end oe", 16'(TRANSFER_END_OE_O), 16'h1);
        chk("end in", 16'(TRANSFER_END_IN_O), 16'h2);
        chk("end out", 16'(TRANSFER_END_O), 16'h2);
        // unused ack and end pins: software clears their enable bits
        ACK_PIN_ENABLE_I = 2'b00;
        END_PIN_ENABLE_I = 2'b00;
        cyc(3);
        chk("ack unused", 16'(DMA_ACK_O), 16'h0);
        chk("end unused oe", 16'(TRANSFER_END_OE_O), 16'h0);
        chk("end unused lvl", 16'(TRANSFER_END_O), 16'h3);
        ACK_PIN_ENABLE_I = 2'b11;
        END_PIN_ENABLE_I = 2'b11;
        TRANSFER_END_I = 2'b11;
        SPLIT_BUS_ENABLE_I = 1;
        SPLIT_READ_DATA_I = 8'h96;
        strobe_n = 0;
        cyc(3);
        chk("split oe", 16'(SPLIT_DATA_OE_O), 16'h1);
        chk("split data", 16'(SPLIT_DATA_O), 16'h0096);
        chk("split strobe", 16'(SPLIT_STROBE_O), 16'h1);
        chk("ch1 ack off", 16'(DMA_ACK_O[1]), 16'h0);
        SPLIT_BUS_ENABLE_I = 0;
        strobe_n = 1;
        cyc(3);
        chk("split off", 16'(SPLIT_DATA_OE_O), 16'h0);
        do_reset(1'b1);
        chk("mux mode", 16'(MUX_MODE_O), 16'h1);
        rd(6'h05, 16'h0000);
        wr(6'h0a, 16'hc3c3, 2'b11);
        wr(6'h0b, 16'h0f0f, 2'b11);
        rd(6'h0a, 16'hc3c3);
        summarize();
    end
endmodule
`default_nettype wire
